// ==== verilog/ddr_wr_pkg.sv ====
// Purpose: shared constants for the write-turnaround link
// Assumes: timing in core_clk cycles (25 ns), except CLK_NS and TRAS_NS in ns
// Notes:   mode fields travel on the link beside the commands
package ddr_wr_pkg;
  localparam int DQ_W       = 8;
  localparam int BANK_W     = 4;
  localparam int BG_W       = 2;
  localparam int NBANK      = 16;
  localparam int CWL_W      = 5;
  localparam int LAT_W      = 6;
  localparam int TIME_W     = 8;
  localparam int WQ_DEPTH   = 4;
  localparam int WBUF_DEPTH = 32;

  typedef enum logic [2:0] {CMD_DES, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_PRE} cmd_e;

  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  localparam int BL8_CLK       = 4;
  localparam int BC4_CLK       = 2;
  localparam int CWL_LOW       = 9;
  localparam int PRE2_CWL_STEP = 1;
  localparam logic [CWL_W-1:0] CWL_PRE2_MIN = CWL_W'(CWL_LOW + PRE2_CWL_STEP);

  localparam int TWR_CYC     = 12;
  localparam int TWR_DBI_CYC = 14;
  localparam int TWTR_S_CYC  = 2;
  localparam int TWTR_L_CYC  = 6;
  localparam int CLK_NS      = 25;
  localparam int TRAS_NS     = 33;
  localparam int TRAS_CYC    = (TRAS_NS + CLK_NS - 1) / CLK_NS;
endpackage : ddr_wr_pkg

// ==== verilog/ddr_link_if.sv ====
// Purpose: command, mode and write-data link between controller and device
// Assumes: one clock; wdq carries two beats per clock, beat 0 in the low half
// Notes:   wr_hold is the device buffer back-pressure
`timescale 1ns/1ps
interface ddr_link_if
  import ddr_wr_pkg::*;
  (input wire logic core_clk,
   input wire logic rst_b);
  cmd_e               cmd;
  logic [BANK_W-1:0]  bank;
  logic               a12;
  logic [2*DQ_W-1:0]  wdq;
  logic               wdq_valid;
  logic [1:0]         mr_bl;
  logic [CWL_W-1:0]   mr_al;
  logic [CWL_W-1:0]   mr_cwl;
  logic               mr_dbi;
  logic               wr_hold;

  modport ctl  (output cmd, bank, a12, wdq, wdq_valid, mr_bl, mr_al, mr_cwl, mr_dbi,
                input wr_hold);
  modport dram (input cmd, bank, a12, wdq, wdq_valid, mr_bl, mr_al, mr_cwl, mr_dbi,
                output wr_hold);
endinterface : ddr_link_if

// ==== verilog/dram_write_end.sv ====
// Purpose: device end: burst decode, write-data capture, auto precharge
// Assumes: controller respects spacing and wr_hold
// Notes:   captured clocks leave through a 32-word buffer
`timescale 1ns/1ps
module wbuf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic [W-1:0]           in_data,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  output logic [W-1:0]                out_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [$clog2(DEPTH+1)-1:0]  level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic          push;
  logic          pop;

  assign in_ready = level != DEPTH[$clog2(DEPTH+1)-1:0];
  assign push     = in_valid && in_ready;
  assign pop      = level != '0 && (!out_valid || out_ready);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp    <= '0;
      rp    <= '0;
      level <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      level <= level + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  // Registered output stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rp];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : wbuf_fifo

module dram_write_end
  import ddr_wr_pkg::*;
#(
  parameter int DW = DQ_W,
  parameter int QD = WQ_DEPTH,
  parameter int BD = WBUF_DEPTH
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  ddr_link_if.dram                     link,
  output logic [2*DW+BANK_W-1:0]       wr_word,
  output logic                         wr_word_valid,
  input  wire logic                    wr_word_ready,
  output logic [NBANK-1:0]             bank_open,
  output logic                         auto_pre,
  output logic [BANK_W-1:0]            auto_pre_bank
);
  localparam int RESERVE = BL8_CLK * (QD + 2);
  if (DW != DQ_W || BD <= RESERVE || QD < 2 || (1 << $clog2(QD)) != QD) begin : g_bad_cfg
    $error("buffer too small, width mismatch or queue depth not a power of two");
  end

  logic [TIME_W-1:0] now;
  logic [TIME_W-1:0] q_due  [QD];
  logic [2:0]        q_win  [QD];
  logic [2:0]        q_dat  [QD];
  logic              q_ap   [QD];
  logic [BANK_W-1:0] q_bank [QD];
  logic [$clog2(QD)-1:0] qw;
  logic [$clog2(QD)-1:0] qr;
  logic [$clog2(QD+1)-1:0] qcnt;
  logic [2:0]        win_left;
  logic [2:0]        dat_left;
  logic              cur_ap;
  logic [BANK_W-1:0] cur_bank;
  logic [TIME_W-1:0] twr_cnt [NBANK];
  logic [LAT_W-1:0]  wl;
  logic              is_wr;
  logic              bc4;
  logic [2:0]        win_clk;
  logic              start;
  logic              data_on;
  logic              wr_end;
  logic              fifo_ready;
  logic [$clog2(BD+1)-1:0] fifo_level;

  assign wl    = LAT_W'(link.mr_al) + LAT_W'(link.mr_cwl);
  assign is_wr = link.cmd == CMD_WR || link.cmd == CMD_WRA;
  assign bc4     = link.mr_bl == BL_FIXED4 || (link.mr_bl == BL_OTF && !link.a12);
  assign win_clk = link.mr_bl == BL_FIXED4 ? 3'(BC4_CLK) : 3'(BL8_CLK);
  assign start   = qcnt != '0 && q_due[qr] == now;
  assign data_on = start || dat_left != '0;
  assign wr_end  = !start && win_left == 3'h1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) now <= '0;
    else now <= now + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (is_wr) begin
      q_due[qw]  <= now + TIME_W'(wl);
      q_win[qw]  <= win_clk;
      q_dat[qw]  <= bc4 ? 3'(BC4_CLK) : 3'(BL8_CLK);
      q_ap[qw]   <= link.cmd == CMD_WRA;
      q_bank[qw] <= link.bank;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qw   <= '0;
      qr   <= '0;
      qcnt <= '0;
    end else begin
      if (is_wr) qw <= qw + 1'b1;
      if (start) qr <= qr + 1'b1;
      qcnt <= qcnt + (is_wr ? 1'b1 : 1'b0) - (start ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_left <= '0;
      dat_left <= '0;
      cur_ap   <= 1'b0;
      cur_bank <= '0;
    end else if (start) begin
      win_left <= q_win[qr] - 3'h1;
      dat_left <= q_dat[qr] - 3'h1;
      cur_ap   <= q_ap[qr];
      cur_bank <= q_bank[qr];
    end else begin
      if (win_left != '0) win_left <= win_left - 3'h1;
      if (dat_left != '0) dat_left <= dat_left - 3'h1;
    end
  end

  wbuf_fifo #(.W(2*DW+BANK_W), .DEPTH(BD)) u_buf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_data   ({start ? q_bank[qr] : cur_bank, link.wdq}),
    .in_valid  (data_on),
    .in_ready  (fifo_ready),
    .out_data  (wr_word),
    .out_valid (wr_word_valid),
    .out_ready (wr_word_ready),
    .level     (fifo_level)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) link.wr_hold <= 1'b0;
    else link.wr_hold <= !fifo_ready || int'(fifo_level) > BD - RESERVE;
  end

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        twr_cnt[b] <= '0;
      end else if (wr_end && cur_ap && cur_bank == BANK_W'(b)) begin
        twr_cnt[b] <= link.mr_dbi ? TIME_W'(TWR_DBI_CYC) : TIME_W'(TWR_CYC);
      end else if (twr_cnt[b] != '0) begin
        twr_cnt[b] <= twr_cnt[b] - 1'b1;
      end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) bank_open[b] <= 1'b0;
      else if (twr_cnt[b] == TIME_W'(1)) bank_open[b] <= 1'b0;
      else if (link.bank == BANK_W'(b) && link.cmd == CMD_ACT) bank_open[b] <= 1'b1;
      else if (link.bank == BANK_W'(b) && link.cmd == CMD_PRE) bank_open[b] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_pre      <= 1'b0;
      auto_pre_bank <= '0;
    end else begin
      auto_pre <= 1'b0;
      for (int b = NBANK - 1; b >= 0; b--) begin
        if (twr_cnt[b] == TIME_W'(1)) begin
          auto_pre      <= 1'b1;
          auto_pre_bank <= BANK_W'(b);
        end
      end
    end
  end
endmodule : dram_write_end

// ==== verilog/ddr_write_ctl.sv ====
// Purpose: controller end: spaces WRITE, READ, PRECHARGE; drives write data
// Assumes: one request held at a time; mode inputs static between bursts
// Notes:   a request waits in a holding register until its spacing is met
`timescale 1ns/1ps
module ddr_write_ctl
  import ddr_wr_pkg::*;
#(
  parameter int DW = DQ_W,
  parameter int QD = WQ_DEPTH
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  ddr_link_if.ctl                   link,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire cmd_e                 req_cmd,
  input  wire logic [BANK_W-1:0]    req_bank,
  input  wire logic                 req_a12,
  input  wire logic [8*DW-1:0]      req_data,
  input  wire logic [1:0]           bl_mode,
  input  wire logic [CWL_W-1:0]     al,
  input  wire logic [CWL_W-1:0]     cwl,
  input  wire logic                 dbi_en,
  input  wire logic                 pre2
);
  if (DW != DQ_W || QD < 2 || (1 << $clog2(QD)) != QD) begin : g_bad_cfg
    $error("unsupported width, or queue depth not a power of two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding register and mode
  logic                hv;
  cmd_e                h_cmd;
  logic [BANK_W-1:0]   h_bank;
  logic                h_a12;
  logic [8*DW-1:0]     h_data;
  logic [CWL_W-1:0]    eff_cwl;
  logic [LAT_W-1:0]    wl;
  logic                h_bc4;
  logic [2:0]          win_clk;
  logic [2:0]          dat_clk;
  logic                issue;
  logic                legal;
  logic                next_hv;
  logic                is_wr;
  logic [TIME_W-1:0]   now;
  logic [TIME_W-1:0]   wtr_s_cnt;
  logic [TIME_W-1:0]   wtr_l_cnt [1<<BG_W];
  logic [TIME_W-1:0]   wrp_cnt   [NBANK];
  logic [TIME_W-1:0]   ras_cnt   [NBANK];
  logic [NBANK-1:0]    opened;
  logic [TIME_W-1:0]   span;
  logic [TIME_W-1:0]   twr_v;
  logic [BG_W-1:0]     h_bg;
  logic [2:0]          wtw_cnt;

  assign eff_cwl = (pre2 && cwl < CWL_PRE2_MIN) ? CWL_PRE2_MIN : cwl;
  assign wl      = LAT_W'(al) + LAT_W'(eff_cwl);
  assign h_bc4   = bl_mode == BL_FIXED4 || (bl_mode == BL_OTF && !h_a12);
  assign win_clk = bl_mode == BL_FIXED4 ? 3'(BC4_CLK) : 3'(BL8_CLK);
  assign dat_clk = h_bc4 ? 3'(BC4_CLK) : 3'(BL8_CLK);
  assign twr_v   = dbi_en ? TIME_W'(TWR_DBI_CYC) : TIME_W'(TWR_CYC);
  assign span    = TIME_W'(wl) + TIME_W'(win_clk) - 1'b1;
  assign h_bg    = h_bank[BANK_W-1 -: BG_W];
  assign is_wr   = h_cmd == CMD_WR || h_cmd == CMD_WRA;

  logic [$clog2(QD+1)-1:0] qcnt;

  always_comb begin
    legal = 1'b0;
    case (h_cmd)
      CMD_ACT: legal = !opened[h_bank] && wrp_cnt[h_bank] == '0;
      CMD_WR, CMD_WRA: legal = opened[h_bank] && !link.wr_hold && int'(qcnt) < QD &&
                               wtw_cnt == '0;
      CMD_RD: legal = opened[h_bank] && wtr_s_cnt == '0 && wtr_l_cnt[h_bg] == '0;
      CMD_PRE: legal = wrp_cnt[h_bank] == '0 && ras_cnt[h_bank] == '0;
      default: legal = 1'b1;
    endcase
  end

  assign issue   = hv && legal;
  assign next_hv = (hv && !issue) || (req_valid && req_ready);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hv        <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      hv        <= next_hv;
      req_ready <= !next_hv;
    end
  end

  always_ff @(posedge core_clk) begin
    if (req_valid && req_ready) begin
      h_cmd  <= req_cmd;
      h_bank <= req_bank;
      h_a12  <= req_a12;
      h_data <= req_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) now <= '0;
    else now <= now + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command and mode drive
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.cmd    <= CMD_DES;
      link.bank   <= '0;
      link.a12    <= 1'b0;
      link.mr_bl  <= BL_FIXED8;
      link.mr_al  <= '0;
      link.mr_cwl <= CWL_W'(CWL_LOW);
      link.mr_dbi <= 1'b0;
    end else begin
      link.cmd    <= issue ? h_cmd : CMD_DES;
      link.bank   <= h_bank;
      link.a12    <= h_a12;
      link.mr_bl  <= bl_mode;
      link.mr_al  <= al;
      link.mr_cwl <= eff_cwl;
      link.mr_dbi <= dbi_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spacing counters
  // short write-to-read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) wtr_s_cnt <= '0;
    else if (issue && is_wr && span + TIME_W'(TWTR_S_CYC) > wtr_s_cnt)
      wtr_s_cnt <= span + TIME_W'(TWTR_S_CYC);
    else if (wtr_s_cnt != '0) wtr_s_cnt <= wtr_s_cnt - 1'b1;
  end

  // whole burst windows
  // Next write waits out the current data window so bursts never overlap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) wtw_cnt <= '0;
    else if (issue && is_wr) wtw_cnt <= win_clk - 3'h1;
    else if (wtw_cnt != '0) wtw_cnt <= wtw_cnt - 3'h1;
  end

  for (genvar g = 0; g < (1 << BG_W); g++) begin : g_bg
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) wtr_l_cnt[g] <= '0;
      else if (issue && is_wr && h_bg == BG_W'(g) && span + TIME_W'(TWTR_L_CYC) > wtr_l_cnt[g])
        wtr_l_cnt[g] <= span + TIME_W'(TWTR_L_CYC);
      else if (wtr_l_cnt[g] != '0) wtr_l_cnt[g] <= wtr_l_cnt[g] - 1'b1;
    end
  end

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic hit;
    assign hit = issue && h_bank == BANK_W'(b);

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) wrp_cnt[b] <= '0;
      else if (hit && is_wr && span + twr_v > wrp_cnt[b]) wrp_cnt[b] <= span + twr_v;
      else if (wrp_cnt[b] != '0) wrp_cnt[b] <= wrp_cnt[b] - 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) ras_cnt[b] <= '0;
      else if (hit && h_cmd == CMD_ACT) ras_cnt[b] <= TIME_W'(TRAS_CYC - 1);
      else if (ras_cnt[b] != '0) ras_cnt[b] <= ras_cnt[b] - 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) opened[b] <= 1'b0;
      else if (hit && h_cmd == CMD_ACT) opened[b] <= 1'b1;
      else if (hit && (h_cmd == CMD_PRE || h_cmd == CMD_WRA)) opened[b] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-data queue and driver
  logic [TIME_W-1:0]       q_due [QD];
  logic [8*DW-1:0]         q_dat [QD];
  logic [2:0]              q_clk [QD];
  logic [$clog2(QD)-1:0]   qw;
  logic [$clog2(QD)-1:0]   qr;
  logic                    launch;
  logic [2:0]              d_left;
  logic [8*DW-1:0]         sh;

  assign launch = qcnt != '0 && q_due[qr] == now;

  always_ff @(posedge core_clk) begin
    if (issue && is_wr) begin
      q_due[qw] <= now + TIME_W'(wl);
      q_dat[qw] <= h_data;
      q_clk[qw] <= dat_clk;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      qw   <= '0;
      qr   <= '0;
      qcnt <= '0;
    end else begin
      if (issue && is_wr) qw <= qw + 1'b1;
      if (launch) qr <= qr + 1'b1;
      qcnt <= qcnt + ((issue && is_wr) ? 1'b1 : 1'b0) - (launch ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.wdq       <= '0;
      link.wdq_valid <= 1'b0;
      d_left         <= '0;
      sh             <= '0;
    end else if (launch) begin
      link.wdq       <= q_dat[qr][2*DW-1:0];
      link.wdq_valid <= 1'b1;
      d_left         <= q_clk[qr] - 3'h1;
      sh             <= q_dat[qr] >> (2*DW);
    end else if (d_left != '0) begin
      link.wdq       <= sh[2*DW-1:0];
      link.wdq_valid <= 1'b1;
      d_left         <= d_left - 3'h1;
      sh             <= sh >> (2*DW);
    end else begin
      link.wdq_valid <= 1'b0;
    end
  end
endmodule : ddr_write_ctl

// ==== verif/ddr_link_monitor.sv ====
// Purpose: link checker for burst length, latency and command spacing
// Assumes: mode fields static while writes are in flight
// Notes:   per-bank, per-group and global down counters count the cycles left until a command is legal
`timescale 1ns/1ps
module ddr_link_monitor
  import ddr_wr_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire cmd_e              cmd,
  input wire logic [BANK_W-1:0] bank,
  input wire logic              a12,
  input wire logic              wdq_valid,
  input wire logic [1:0]        mr_bl,
  input wire logic [CWL_W-1:0]  mr_al,
  input wire logic [CWL_W-1:0]  mr_cwl,
  input wire logic              mr_dbi
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic [63:0]       hist, chop, fix;
  logic [TIME_W-1:0] pre_cnt [NBANK];
  logic [TIME_W-1:0] ras_cnt [NBANK];
  logic [TIME_W-1:0] wtr_l [4];
  logic [TIME_W-1:0] wtr_s, dl;
  logic [LAT_W-1:0]  wl;
  logic              wr_now, fix_now, st;

  assign wl = LAT_W'(mr_al) + LAT_W'(mr_cwl);
  assign fix_now = mr_bl == BL_FIXED4;
  assign wr_now = cmd == CMD_WR || cmd == CMD_WRA;
  assign dl = TIME_W'(wl) + TIME_W'(fix_now ? BC4_CLK : BL8_CLK) - TIME_W'(1);
  assign st = hist[wl-1];

  // Burst history, bit k set when a write issued k+1 cycles ago
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist <= '0;
      chop <= '0;
      fix  <= '0;
    end else begin
      hist <= {hist[62:0], wr_now};
      chop <= {chop[62:0], fix_now || (mr_bl == BL_OTF && !a12)};
      fix  <= {fix[62:0], fix_now};
    end
  end

  // Spacing counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wtr_s <= '0;
      for (int i = 0; i < NBANK; i++) begin
        pre_cnt[i] <= '0;
        ras_cnt[i] <= '0;
      end
      for (int g = 0; g < 4; g++) wtr_l[g] <= '0;
    end else begin
      wtr_s <= wr_now ? dl + TIME_W'(TWTR_S_CYC) : wtr_s - TIME_W'(wtr_s != 0);
      for (int i = 0; i < NBANK; i++) begin
        if (wr_now && bank == i)
          pre_cnt[i] <= dl + TIME_W'(mr_dbi ? TWR_DBI_CYC : TWR_CYC);
        else if (pre_cnt[i] != 0) pre_cnt[i] <= pre_cnt[i] - TIME_W'(1);
        if (cmd == CMD_ACT && bank == i) ras_cnt[i] <= TIME_W'(TRAS_CYC - 1);
        else if (ras_cnt[i] != 0) ras_cnt[i] <= ras_cnt[i] - TIME_W'(1);
      end
      for (int g = 0; g < 4; g++) begin
        if (wr_now && bank[3:2] == g) wtr_l[g] <= dl + TIME_W'(TWTR_L_CYC);
        else if (wtr_l[g] != 0) wtr_l[g] <= wtr_l[g] - TIME_W'(1);
      end
    end
  end

  sequence s_bl8;
    wdq_valid [*4];
  endsequence
  sequence s_otf_chop;
    wdq_valid [*2] ##1 !wdq_valid [*2];
  endsequence
  sequence s_fix_chop;
    wdq_valid [*2] ##1 (!wdq_valid || st);
  endsequence

  chk_wl_first: assert property (st |-> wdq_valid)
    else $error("write data missing at write latency");
  chk_wl_start: assert property ($rose(wdq_valid) |-> st)
    else $error("write data started off write latency");
  chk_burst_eight: assert property (st && !chop[wl-1] |-> s_bl8)
    else $error("eight beat burst not four data clocks");
  chk_otf_chop: assert property (st && chop[wl-1] && !fix[wl-1] |-> s_otf_chop)
    else $error("on the fly chop not two data clocks");
  chk_fixed_chop: assert property (st && fix[wl-1] |-> s_fix_chop)
    else $error("fixed chop not two data clocks");
  chk_pre_recovery: assert property (cmd == CMD_PRE |-> pre_cnt[bank] == 0)
    else $error("precharge before write recovery");
  chk_pre_active: assert property (cmd == CMD_PRE |-> ras_cnt[bank] == 0)
    else $error("precharge before activate time");
  chk_read_turn: assert property (cmd == CMD_RD |-> wtr_s == 0 && wtr_l[bank[3:2]] == 0)
    else $error("read before write to read time");
endmodule : ddr_link_monitor

// ==== verif/tb_ddr_write_turnaround_timing.sv ====
// Purpose: end to end bench of controller and device over the link
// Assumes: modes change only while the link is idle
// Notes:   word and auto precharge notes are queued and compared in order
`timescale 1ns/1ps
module tb_ddr_write_turnaround_timing
  import ddr_wr_pkg::*;
;
  logic        core_clk = 0;
  logic        rst_b = 0;
  logic        req_valid = 0;
  logic        req_ready, req_a12 = 0, dbi_en = 0, pre2 = 0;
  logic        wr_word_ready = 1, wr_word_valid, auto_pre, stall = 0, hold_seen = 0;
  cmd_e        req_cmd = CMD_DES;
  logic [3:0]  req_bank = '0, auto_pre_bank;
  logic [63:0] req_data = '0;
  logic [1:0]  bl_mode = BL_FIXED8;
  logic [4:0]  al = '0, cwl = 5'h9;
  logic [19:0] wr_word, ew;
  logic [15:0] bank_open;
  logic [35:0] ea;
  logic [31:0] cyc = '0;
  logic [19:0] wq[$];
  logic [35:0] apq[$];
  int          fail_count = 0;
  int          comparisons = 0;

  always #12.5 core_clk = ~core_clk;

  ddr_link_if i_ddr_link_if (.core_clk, .rst_b);
  ddr_write_ctl i_ddr_write_ctl (.core_clk, .rst_b, .link(i_ddr_link_if), .req_valid,
    .req_ready, .req_cmd, .req_bank, .req_a12, .req_data, .bl_mode, .al, .cwl, .dbi_en, .pre2);
  dram_write_end i_dram_write_end (.core_clk, .rst_b, .link(i_ddr_link_if), .wr_word,
    .wr_word_valid, .wr_word_ready, .bank_open, .auto_pre, .auto_pre_bank);
  ddr_link_monitor i_ddr_link_monitor (.core_clk, .rst_b, .cmd(i_ddr_link_if.cmd),
    .bank(i_ddr_link_if.bank), .a12(i_ddr_link_if.a12), .wdq_valid(i_ddr_link_if.wdq_valid),
    .mr_bl(i_ddr_link_if.mr_bl), .mr_al(i_ddr_link_if.mr_al), .mr_cwl(i_ddr_link_if.mr_cwl),
    .mr_dbi(i_ddr_link_if.mr_dbi));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] sn);
    comparisons++;
    if (ex !== sn) begin
      $display("unexpected %s expected %h seen %h", nm, ex, sn);
      fail_count++;
    end
  endtask : chk

  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // Auto precharge cycle after the write command
  function automatic logic [31:0] apd();
    logic [4:0] c;
    c = (pre2 && cwl < CWL_PRE2_MIN) ? CWL_PRE2_MIN : cwl;
    return al + c + (bl_mode == BL_FIXED4 ? BC4_CLK : BL8_CLK) + (dbi_en ? TWR_DBI_CYC : TWR_CYC);
  endfunction : apd

  // Entered and left at a falling edge
  task automatic send(input cmd_e c, input logic [3:0] b, input logic a);
    int          n;
    logic [63:0] d;
    n = 0;
    d = {$urandom, $urandom};
    req_valid = 1;
    req_cmd = c;
    req_bank = b;
    req_a12 = a;
    req_data = d;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    req_valid <= 0;
    @(negedge core_clk);
    if (n >= 400) chk("req_ready", 1, 0);
    if (c == CMD_WR || c == CMD_WRA)
      for (int k = 0; k < ((bl_mode == BL_FIXED4 || (bl_mode == BL_OTF && !a)) ? 2 : 4); k++)
        wq.push_back({b, d[16*k +: 16]});
  endtask : send

  task automatic drain;
    int n;
    n = 0;
    while ((wq.size() > 0 || apq.size() > 0) && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    repeat (20) @(negedge core_clk);
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk) wr_word_ready <= !stall && ($urandom % 4 != 0);

  always @(posedge core_clk) begin
    if (rst_b && wr_word_valid && wr_word_ready) begin
      ew = (wq.size() > 0) ? wq.pop_front() : 'x;
      chk("wr_word", ew, wr_word);
    end
    if (rst_b && auto_pre) begin
      ea = (apq.size() > 0) ? apq.pop_front() : 'x;
      chk("auto_pre", ea, {auto_pre_bank, cyc});
    end
    if (i_ddr_link_if.cmd == CMD_WRA) apq.push_back({i_ddr_link_if.bank, cyc + apd()});
    if (i_ddr_link_if.wr_hold) hold_seen <= 1;
    cyc <= cyc + 1;
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(82504));
    repeat (16) @(negedge core_clk);
    rst_b = 1;
    @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      logic [3:0] b;
      logic       a;
      b = 4'($urandom);
      bl_mode = (i % 4 == 3) ? BL_FIXED4 : (i % 4 == 0) ? BL_FIXED8 : BL_OTF;
      a = (i % 4 == 1) ? 1'b1 : (i % 4 == 2) ? 1'b0 : 1'($urandom);
      pre2 = (i == 1);
      dbi_en = 1'(i / 2);
      al = (i == 1) ? 5'h0 : 5'($urandom % 3);
      cwl = (i == 1) ? 5'h9 : 5'(9 + $urandom % 4);
      repeat (3) @(negedge core_clk);
      if (i == 1) chk("mr_cwl", CWL_PRE2_MIN, i_ddr_link_if.mr_cwl);
      send(CMD_ACT, b, 0);
      send(CMD_ACT, b ^ 4'h4, 0);
      send(CMD_WR, b, a);
      chk("bank_open", (16'h1 << b) | (16'h1 << (b ^ 4'h4)), bank_open);
      send(CMD_WR, b, a);
      send(CMD_RD, b ^ 4'h4, a);
      send(CMD_RD, b, a);
      send(CMD_PRE, b, 0);
      send(CMD_WRA, b ^ 4'h4, a);
      drain();
      chk("bank_open", 0, bank_open);
    end
    // Stall the far side for 150 clocks so the buffer pushes back, then drain
    bl_mode = BL_FIXED8;
    stall <= 1;
    send(CMD_ACT, 4'h3, 0);
    fork
      repeat (12) send(CMD_WR, 4'h3, 1);
      begin
        repeat (150) @(negedge core_clk);
        stall <= 0;
      end
    join
    send(CMD_PRE, 4'h3, 0);
    drain();
    chk("wr_hold", 1, hold_seen);
    chk("pending", 0, wq.size() + apq.size());
    chk("bank_open", 0, bank_open);
    end_sim();
  end
endmodule : tb_ddr_write_turnaround_timing
